// [design/pin_notify_consts.vh]
/*
 * Constants for the UART-side pin control and serial-state notification block:
 * register indices, field positions, reset values and packet field values.
 * Assumes an APB bus with 32-bit data; byte address is four times the index.
 */
`ifndef PIN_NOTIFY_CONSTS_VH
`define PIN_NOTIFY_CONSTS_VH

// ==========================================================================
// register indices (byte address = index * 4)
`define IDX_PIN_DIRECTION 10'h04D
`define IDX_PIN_OUTPUT_SET 10'h04E
`define IDX_PIN_OUTPUT_CLEAR 10'h04F
`define IDX_PIN_LEVEL_STATUS 10'h050
`define IDX_PIN_CHANGE_NOTIFY_MASK 10'h051
`define IDX_CUSTOM_NOTIFY_FORMAT_ENABLE 10'h052
`define IDX_NOTIFY_STATE 10'h070

// ==========================================================================
// reset values
`define RST_PIN_DIRECTION 6'h00
`define RST_PIN_OUTPUT 6'h00
`define RST_PIN_MASK 6'h00
`define RST_CUSTOM_FORMAT 1'h0

// ==========================================================================
// field positions
`define FLD_PINS_MSB 5
`define FLD_FORMAT_BIT 0
`define NST_PENDING_BIT 0
`define NST_BUSY_BIT 1
`define NST_EVENT_LSB 4
`define NST_CHANGE_LSB 8

// ==========================================================================
// notification packet
`define PKT_REQUEST_TYPE 8'hA1
`define PKT_SERIAL_STATE 8'h20
`define PKT_VALUE 16'h0000
`define PKT_INDEX 16'h0000
`define PKT_LEN_STANDARD 16'h0002
`define PKT_LEN_CUSTOM 16'h0004
`define PKT_BYTES_STANDARD 4'hA
`define PKT_BYTES_CUSTOM 4'hC

`endif

// [design/pin_notify.v]
/*
 * Six UART-side general-purpose pins with set/clear output control, level
 * status and per-pin change masking, plus the serial-state notification
 * packet builder (standard two-byte or vendor four-byte data).
 * Assumes pin inputs and event inputs are synchronous to pclk; error event
 * inputs are one-cycle pulses from the UART receive logic.
 * Pin pull resistors and the usb transport sit outside this block.
 * A formed packet is always sent to its last byte; triggers that arrive
 * meanwhile queue exactly one further packet.
 */
// The APB interface to the registers was left to the implementer.

`include "pin_notify_consts.vh"

module pin_notify
(
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // pins, order rts cts dtr dsr cd ri from bit 5 down
    input wire [5:0] pin_in,
    output wire [5:0] pin_out,
    output wire [5:0] pin_oe,
    // uart receive events and state
    input wire overrun_event,
    input wire parity_event,
    input wire frame_event,
    input wire break_event,
    input wire break_active,
    // notification byte stream toward the usb interrupt endpoint
    output wire pkt_valid,
    output wire [7:0] pkt_data,
    output wire pkt_last,
    input wire pkt_ready
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    // index of the final byte, counted down from here
    localparam [3:0] LAST_STD = `PKT_BYTES_STANDARD - 4'h1;
    localparam [3:0] LAST_CUS = `PKT_BYTES_CUSTOM - 4'h1;

    reg [5:0] dir_r;
    reg [5:0] out_r;
    reg [5:0] out_nxt;
    reg [5:0] mask_r;
    reg custom_r;
    reg [5:0] prev_r;
    reg [5:0] chg_r;
    reg [3:0] ev_r;
    reg pending_r;
    reg state_r;
    reg [95:0] shift_r;
    reg [3:0] count_r;

    wire [9:0] reg_idx;
    wire idx_ok;
    wire wr_en;
    wire rd_en;
    wire [5:0] pin_change;
    wire [3:0] ev_in;
    wire trigger;
    wire form;
    wire take;
    wire [31:0] std_data;
    wire [31:0] cus_data;
    wire [31:0] pkt_word;
    wire [15:0] pkt_len;
    wire [63:0] pkt_head;
    wire [31:0] nst_word;
    wire [5:0] pin_wake;
    wire [6:0] std_bits;
    wire wr_dir;
    wire wr_set;
    wire wr_clr;
    wire wr_mask;
    wire wr_fmt;
    reg [31:0] rd_nxt;
    reg [5:0] chg_nxt;
    reg [3:0] ev_nxt;
    reg pending_nxt;
    reg state_nxt;
    reg [95:0] shift_nxt;
    reg [3:0] count_nxt;
    reg started_r;

    // index decode shared by write enable and slave error
    function is_mapped;
        input [9:0] idx;
        begin
            is_mapped = (idx == `IDX_PIN_DIRECTION) || (idx == `IDX_PIN_OUTPUT_SET) ||
                        (idx == `IDX_PIN_OUTPUT_CLEAR) || (idx == `IDX_PIN_LEVEL_STATUS) ||
                        (idx == `IDX_PIN_CHANGE_NOTIFY_MASK) ||
                        (idx == `IDX_CUSTOM_NOTIFY_FORMAT_ENABLE) || (idx == `IDX_NOTIFY_STATE);
        end
    endfunction

    // ======================================================================
    // apb access
    assign reg_idx = paddr[11:2];
    assign idx_ok = is_mapped(reg_idx);
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~idx_ok;
    assign wr_en = psel & penable & pwrite & idx_ok;
    assign rd_en = psel & ~penable & ~pwrite;

    // one strobe per writable register, shared by the register and pin processes
    assign wr_dir = wr_en & (reg_idx == `IDX_PIN_DIRECTION);
    assign wr_set = wr_en & (reg_idx == `IDX_PIN_OUTPUT_SET);
    assign wr_clr = wr_en & (reg_idx == `IDX_PIN_OUTPUT_CLEAR);
    assign wr_mask = wr_en & (reg_idx == `IDX_PIN_CHANGE_NOTIFY_MASK);
    assign wr_fmt = wr_en & (reg_idx == `IDX_CUSTOM_NOTIFY_FORMAT_ENABLE);

    // debug view of the notifier: pending, busy, event and change accumulators
    assign nst_word = {18'h00000, chg_r, ev_r, 2'h0, state_r, pending_r};

    // read word for the addressed register; write-only and unmapped read zero
    always @*
    begin
        rd_nxt = 32'h00000000;
        case (reg_idx)
            `IDX_PIN_DIRECTION:
                rd_nxt = {26'h0000000, dir_r};
            `IDX_PIN_LEVEL_STATUS:
                rd_nxt = {26'h0000000, pin_in};
            `IDX_PIN_CHANGE_NOTIFY_MASK:
                rd_nxt = {26'h0000000, mask_r};
            `IDX_CUSTOM_NOTIFY_FORMAT_ENABLE:
                rd_nxt = {31'h00000000, custom_r};
            `IDX_NOTIFY_STATE:
                rd_nxt = nst_word;
            default:
                rd_nxt = 32'h00000000;
        endcase
    end

    // read data is captured in the setup cycle so prdata is a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_en)
            prdata <= rd_nxt;
    end

    // ======================================================================
    // configuration registers
    // reserved bits are simply not stored, so software writing them has no effect
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_r <= `RST_PIN_DIRECTION;
            mask_r <= `RST_PIN_MASK;
            custom_r <= `RST_CUSTOM_FORMAT;
        end
        else if (wr_en)
        begin
            if (wr_dir)
                dir_r <= pwdata[`FLD_PINS_MSB:0];
            if (wr_mask)
                mask_r <= pwdata[`FLD_PINS_MSB:0];
            if (wr_fmt)
                custom_r <= pwdata[`FLD_FORMAT_BIT];
        end
    end

    // ======================================================================
    // output pins
    always @*
    begin
        out_nxt = out_r;
        if (wr_set)
            out_nxt = out_r | (pwdata[`FLD_PINS_MSB:0] & dir_r);
        if (wr_clr)
            out_nxt = out_r & ~(pwdata[`FLD_PINS_MSB:0] & dir_r);
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_r <= `RST_PIN_OUTPUT;
        else
            out_r <= out_nxt;
    end

    assign pin_out = out_r;
    assign pin_oe = dir_r;

    // ======================================================================
    // change and event accumulation
    // every pin is watched for change; the mask only gates the wake-up
    genvar g;
    generate
        for (g = 0; g <= `FLD_PINS_MSB; g = g + 1)
        begin : pin_track
            assign pin_change[g] = pin_in[g] ^ prev_r[g];
            assign pin_wake[g] = pin_change[g] & ~mask_r[g];
        end
    endgenerate

    assign ev_in = {overrun_event, parity_event, frame_event, break_event};
    assign trigger = (|pin_wake) | (|ev_in);
    assign form = (state_r == ST_IDLE) & pending_r;

    // prev_r only starts tracking after reset; a first compare against zero is avoided by
    // loading the live level on the first cycle out of reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            started_r <= 1'b0;
        else
            started_r <= 1'b1;
    end

    // cleared when the packet is formed; a new event in that cycle wins
    always @*
    begin
        chg_nxt = chg_r;
        ev_nxt = ev_r;
        pending_nxt = pending_r;
        if (started_r)
        begin
            // every pin counts for change, mask or not
            chg_nxt = (form ? 6'h00 : chg_r) | pin_change;
            ev_nxt = (form ? 4'h0 : ev_r) | ev_in;
            pending_nxt = (form ? 1'b0 : pending_r) | trigger;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r <= 6'h00;
            chg_r <= 6'h00;
            ev_r <= 4'h0;
            pending_r <= 1'b0;
        end
        else
        begin
            prev_r <= pin_in;
            chg_r <= chg_nxt;
            ev_r <= ev_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ======================================================================
    // packet formation
    // standard word, bits 15..7 zero
    // overrun, parity, framing, ring level, break state
    // dsr level bit 1, cd level bit 0
    assign std_bits[6] = ev_r[3];
    assign std_bits[5] = ev_r[2];
    assign std_bits[4] = ev_r[1];
    // ring and carrier bits are the live pin levels at formation
    assign std_bits[3] = pin_in[0];
    assign std_bits[2] = break_active;
    assign std_bits[1] = pin_in[2];
    assign std_bits[0] = pin_in[1];
    assign std_data = {16'h0000, 9'h000, std_bits};
    // error events in 19..16, 31..20 zero
    assign cus_data = {12'h000, ev_r, 2'h0, pin_in, 2'h0, chg_r};
    assign pkt_word = custom_r ? cus_data : std_data;
    assign pkt_len = custom_r ? `PKT_LEN_CUSTOM : `PKT_LEN_STANDARD;
    assign take = (state_r == ST_SEND) & pkt_ready;
    // request type then serial state code
    assign pkt_head = {pkt_len, `PKT_INDEX, `PKT_VALUE, `PKT_SERIAL_STATE, `PKT_REQUEST_TYPE};

    // ======================================================================
    // packet sender
    // a formed packet is never cut short, so the host always sees whole packets
    always @*
    begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        count_nxt = count_r;
        case (state_r)
            ST_IDLE:
            begin
                if (pending_r)
                begin
                    shift_nxt = {pkt_word, pkt_head};
                    count_nxt = custom_r ? LAST_CUS : LAST_STD;
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (take)
                begin
                    shift_nxt = {8'h00, shift_r[95:8]};
                    count_nxt = count_r - 4'h1;
                    if (count_r == 4'h0)
                        state_nxt = ST_IDLE;
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_IDLE;
            shift_r <= 96'h0;
            count_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            count_r <= count_nxt;
        end
    end

    assign pkt_valid = (state_r == ST_SEND);
    assign pkt_data = shift_r[7:0];
    assign pkt_last = (state_r == ST_SEND) & (count_r == 4'h0);

endmodule // pin_notify

// [test/pin_notify_asserts.sv]
/* checker for pin_notify: packet framing, output change cause, refused reads
   assumes it is bound to the pin_notify ports, one clock domain */
module pin_notify_asserts
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // pins and packet stream
    input wire logic [5:0] pin_out,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic pkt_last,
    input wire logic pkt_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] bi_r;
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    // ==========================================
    // byte position inside the packet
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bi_r <= 4'h0;
        else if (pkt_valid && pkt_ready)
            bi_r <= pkt_last ? 4'h0 : bi_r + 4'h1;
    end
    sequence s_take;
        pkt_valid && pkt_ready;
    endsequence
    // ==========================================
    // properties
    a_first_byte: assert property (pkt_valid && bi_r == 4'h0 |-> pkt_data == 8'hA1)
        else $error("bad request type byte");
    a_code_byte: assert property (pkt_valid && bi_r == 4'h1 |-> pkt_data == 8'h20)
        else $error("bad notification code byte");
    a_zero_hdr: assert property (pkt_valid && bi_r inside {2, 3, 4, 5, 7} |-> pkt_data == 8'h00)
        else $error("nonzero value or index byte");
    a_len_low: assert property (pkt_valid && bi_r == 4'h6 |-> pkt_data inside {8'h02, 8'h04})
        else $error("bad length byte");
    a_pkt_size: assert property (pkt_valid && pkt_last |-> bi_r == 4'h9 || bi_r == 4'hB)
        else $error("bad packet size");
    a_hold_byte: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data))
        else $error("byte dropped before taken");
    a_end_drop: assert property (s_take ##0 pkt_last |=> !pkt_valid)
        else $error("valid stayed after last byte");
    a_out_cause: assert property ($changed(pin_out) |-> $past(wr_acc))
        else $error("pin output changed without write");
    a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
endmodule // pin_notify_asserts

// [test/usb_host_model.sv]
/* host side of the interrupt endpoint: takes packet bytes, stalls on command
   assumes stall is driven by the bench, bytes arrive lowest first */
module usb_host_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // packet stream
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic pkt_last,
    output logic pkt_ready,
    // stall control and collected packet, byte count on top
    input wire logic stall,
    output logic got_done,
    output logic [99:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic [95:0] acc = '0;
    assign pkt_ready = !stall;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 4'h0;
            got_done <= 1'b0;
        end
        else
        begin
            got_done <= 1'b0;
            if (pkt_valid && pkt_ready)
            begin
                acc[8*cnt_r +: 8] = pkt_data;
                cnt_r <= pkt_last ? 4'h0 : cnt_r + 4'h1;
                if (pkt_last)
                begin
                    got <= {cnt_r + 4'h1, acc};
                    got_done <= 1'b1;
                    acc = '0;
                end
            end
        end
    end
endmodule // usb_host_model

// [test/pin_notify_tb_top.sv]
/* bench for pin_notify: register reads, output set/clear, notification packets
   assumes the host model beside it and the checker bound below */
`include "pin_notify_consts.vh"
module pin_notify_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pkt_valid, pkt_last, pkt_ready, got_done, break_active = 1'b0, stall = 1'b0;
    logic [5:0] pin_in = 6'h00, pin_out, pin_oe, last_pins = 6'h00;
    logic [3:0] ev_in = 4'h0;
    logic [7:0] pkt_data;
    logic [99:0] got, exp_q[$];
    logic [9:0] ia[7] = '{`IDX_PIN_DIRECTION, `IDX_PIN_OUTPUT_SET, `IDX_PIN_OUTPUT_CLEAR, `IDX_PIN_LEVEL_STATUS,
        `IDX_PIN_CHANGE_NOTIFY_MASK, `IDX_CUSTOM_NOTIFY_FORMAT_ENABLE, 10'h000};
    integer n_fail = 0, check_count = 0, n_pkt = 0, seed = 51;
    always #2 pclk = ~pclk;
    always @(posedge pclk) stall <= $random(seed);
    pin_notify uut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .overrun_event(ev_in[3]),
        .parity_event(ev_in[2]), .frame_event(ev_in[1]), .break_event(ev_in[0]), .break_active(break_active),
        .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
    usb_host_model host(.pclk(pclk), .presetn(presetn), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_ready(pkt_ready), .stall(stall), .got_done(got_done), .got(got));
    task chk(input string what, input logic [99:0] seen, input logic [99:0] e);
        check_count++;
        if (seen !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        r = prdata;
        {psel, penable} <= 2'b00;
        if (n >= 50)
        begin
            n_fail++;
            final_report();
        end
    endtask
    // ==========================================
    // one trigger, expected packet noted first
    task send(input logic [3:0] ev, input logic [5:0] v, input logic f);
        logic [31:0] d;
        int k0;
        d = f ? {12'h0, ev, 2'h0, v, 2'h0, last_pins ^ v} : {25'h0, ev[3:1], v[0], break_active, v[2], v[1]};
        exp_q.push_back(f ? {4'hC, d, 48'h000400000000, 16'h20A1} :
            {4'hA, 16'h0, d[15:0], 48'h000200000000, 16'h20A1});
        k0 = n_pkt;
        {pin_in, ev_in} <= {v, ev};
        @(posedge pclk);
        ev_in <= 4'h0;
        last_pins = v;
        for (int k = 0; k < 200 && n_pkt == k0; k++) @(posedge pclk);
        chk("packet count", n_pkt, k0 + 1);
        if (n_pkt == k0)
            final_report();
    endtask
    always @(posedge pclk)
        if (got_done === 1'b1)
        begin
            n_pkt++;
            chk("packet", got, exp_q.size() ? exp_q.pop_front() : 100'h0);
        end
    initial
    begin
        logic [31:0] r, e;
        logic [5:0] d, v;
        logic [3:0] ev;
        int m0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, ia[i], 32'h0, r);
            chk("reset read", r, 100'h0);
        end
        $display("reset test done");
        d = $random(seed);
        apb(1'b1, `IDX_PIN_DIRECTION, {26'h0, d}, r);
        e = 32'h0;
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            apb(1'b1, i[0] ? `IDX_PIN_OUTPUT_CLEAR : `IDX_PIN_OUTPUT_SET, {26'h0, v}, r);
            e[5:0] = i[0] ? e[5:0] & ~(v & d) : e[5:0] | (v & d);
            @(posedge pclk);
            #1;
            chk("pin_out", pin_out, e[5:0]);
            chk("pin_oe", pin_oe, d);
        end
        $display("output test done");
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, `IDX_CUSTOM_NOTIFY_FORMAT_ENABLE, {31'h0, i[0]}, r);
            apb(1'b1, `IDX_PIN_CHANGE_NOTIFY_MASK, i[1] ? 32'h3F : 32'h0, r);
            {v, ev} = {~pin_in ^ 6'($random(seed)), 4'($random(seed))};
            v = (v == pin_in) ? ~v : v;
            break_active <= i[2];
            @(posedge pclk);
            if (i[1])
            begin
                m0 = n_pkt;
                pin_in <= v;
                repeat (20) @(posedge pclk);
                chk("masked change", n_pkt, m0);
                ev[0] = 1'b1;
            end
            send(ev, v, i[0]);
            apb(1'b0, `IDX_PIN_LEVEL_STATUS, 32'h0, r);
            chk("pin status", r, {26'h0, v});
        end
        $display("notify test done");
        final_report();
    end
endmodule // pin_notify_tb_top
bind pin_notify pin_notify_asserts chk_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .pin_out(pin_out), .pkt_valid(pkt_valid),
    .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
